// File: design/ssd_top.sv
// status flags, baud select and split data buffer of the serial interface
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - set receive-full each time a completed byte enters the receive register
// - interrupt when receive-full and receive interrupt enable are both set
// - a data register read clears receive-full unless a byte enters the receive register in the same cycle
// - error enable lets overrun and mode fault request interrupts, else neither
// - set overrun when a byte arrives while the previous is unread
// - on overrun keep the held byte, drop the new one
// - clear overrun by status read seeing it, then data read
// - slave: mode fault when select rises during a transmission
// - master: mode fault whenever select is low
// - clear mode fault by status read seeing it, then data write
// - set transmit-empty on hand-over to shifter; interrupt if enabled
// - idle: written byte reaches shifter and empty reasserts within two cycles
// - slave mid-transmission defers shifter load until it completes
// - reset sets transmit-empty, clears other flags, error enable, rate bits
// - mode fault sets only with fault detect on; disabling keeps it
// - master: select is general I/O when detect off, interface input when on
// - slave: select never general I/O; detect off only stops mode fault
// - master rate codes 00..11 give divisor 2, 8, 32, 128; none in slave
// - master serial clock equals base clock over twice the divisor
// - data writes go to transmit buffer, reads come from receive buffer
// - slave with select high: serial output off, serial clocks ignored
// - transmit and receive interrupt enables are read/write, reset clear
module ssd_top
   import ssd_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       clk_en,
   input  wire logic [1:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       shift_done,
   input  wire logic [7:0] shift_rx_byte,
   input  wire logic       xfer_active,
   output logic            shift_load,
   output logic      [7:0] shift_tx_byte,
   input  wire logic       ss_n_pin,
   output logic            ss_gpio_sel,
   output logic            miso_oe_n,
   output logic            sclk_ignore,
   output logic            baud_tick,
   output logic            irq
);

   // ***********************************************
   // storage
   // ***********************************************
   logic [7:0] ctrl_q;
   logic       rx_full_q;
   logic       overrun_q;
   logic       mode_fault_q;
   logic       tx_empty_q;
   logic       err_irq_en_q;
   logic       fault_detect_en_q;
   logic [1:0] rate_sel_q;
   logic [7:0] rx_buf_q;
   logic [7:0] tx_buf_q;
   logic       ovr_arm_q;
   logic       mode_fault_flag_arm_q;
   logic       ss_meta_q;
   logic       ss_sync_q;
   logic       ss_prev_q;
   logic [6:0] baud_cnt_q;

   logic       is_on;
   logic       is_master;
   logic       is_slave;
   logic       wr_stat;
   logic       wr_data;
   logic       rd_stat;
   logic       rd_data;
   logic       rx_take;
   logic       rx_lost;
   logic       tx_go;
   logic       mode_fault_flag_set;
   logic [7:0] stat_word;
   logic [7:0] divisor;
   logic       wr_ctrl;
   logic       irq_rx;
   logic       irq_tx;
   logic       irq_err;
   logic       baud_run;
   logic       baud_last;

   // decoded mode and strobes
   assign is_on     = ctrl_q[SSD_CTL_ON_BIT];
   assign is_master = is_on & ctrl_q[SSD_CTL_MSTR_BIT];
   assign is_slave  = is_on & ~ctrl_q[SSD_CTL_MSTR_BIT];
   assign wr_ctrl   = reg_wr & (reg_addr == SSD_OFF_CTRL);
   assign wr_stat   = reg_wr & (reg_addr == SSD_OFF_STAT);
   assign wr_data   = reg_wr & (reg_addr == SSD_OFF_DATA);
   assign rd_stat   = reg_rd & (reg_addr == SSD_OFF_STAT);
   assign rd_data   = reg_rd & (reg_addr == SSD_OFF_DATA);

   // status word as software sees it
   assign stat_word = {rx_full_q, err_irq_en_q, overrun_q, mode_fault_q,
                       tx_empty_q, fault_detect_en_q, rate_sel_q};

   // ***********************************************
   // register bus
   // ***********************************************

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= SSD_CTL_RST;
      end else if (clk_en && wr_ctrl) begin
         ctrl_q <= {4'h0, reg_wdata[3:0]};
      end
   end

   // writable status bits cleared by reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         err_irq_en_q      <= SSD_FLAG_RST;
         fault_detect_en_q <= SSD_FLAG_RST;
         rate_sel_q        <= SSD_RATE_RST;
      end else if (clk_en && wr_stat) begin
         err_irq_en_q      <= reg_wdata[SSD_ST_ERR_IRQ_EN_BIT];
         fault_detect_en_q <= reg_wdata[SSD_ST_FDEN_BIT];
         rate_sel_q        <= {reg_wdata[SSD_ST_RHI_BIT], reg_wdata[SSD_ST_RLO_BIT]};
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= SSD_BYTE_RST;
      end else if (clk_en) begin
         if (!reg_rd) begin
            reg_rdata <= SSD_BYTE_RST;
         end else begin
            case (reg_addr)
               SSD_OFF_CTRL: reg_rdata <= ctrl_q;
               SSD_OFF_STAT: reg_rdata <= stat_word;
               SSD_OFF_DATA: reg_rdata <= rx_buf_q;
               default:      reg_rdata <= SSD_BYTE_RST;  // unmapped reads zero
            endcase
         end
      end
   end

   // ***********************************************
   // receive side
   // ***********************************************

   // byte arrives while previous unread
   // a data read in the same cycle frees the buffer, so no overrun then
   assign rx_lost = shift_done & rx_full_q & ~rd_data;
   assign rx_take = shift_done & ~rx_lost;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rx_buf_q <= SSD_BYTE_RST;
      end else if (clk_en && rx_take) begin
         rx_buf_q <= shift_rx_byte;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rx_full_q <= SSD_FLAG_RST;
      end else if (clk_en) begin
         if (rx_take) begin
            rx_full_q <= 1'b1;
         end else if (rd_data) begin
            rx_full_q <= 1'b0;
         end
      end
   end

   // arms load from status reads that see the flag
   // a new status read re-takes the arm; the matching access drops it
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ovr_arm_q  <= 1'b0;
         mode_fault_flag_arm_q <= 1'b0;
      end else if (clk_en) begin
         if (rd_stat) begin
            ovr_arm_q <= overrun_q;
         end else if (rd_data) begin
            ovr_arm_q <= 1'b0;
         end
         if (rd_stat) begin
            mode_fault_flag_arm_q <= mode_fault_q;
         end else if (wr_data) begin
            mode_fault_flag_arm_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         overrun_q <= SSD_FLAG_RST;
      end else if (clk_en) begin
         if (rx_lost) begin
            overrun_q <= 1'b1;
         end else if (rd_data && ovr_arm_q) begin
            overrun_q <= 1'b0;
         end
      end
   end

   // ***********************************************
   // slave select and mode fault
   // ***********************************************

   // two-stage sync of the select pin
   // stages reset high, the idle pin level, so no false rise after reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ss_meta_q <= 1'b1;
         ss_sync_q <= 1'b1;
         ss_prev_q <= 1'b1;
      end else if (clk_en) begin
         ss_meta_q <= ss_n_pin;
         ss_sync_q <= ss_meta_q;
         ss_prev_q <= ss_sync_q;
      end
   end

   // master ignores select with detect off
   assign mode_fault_flag_set = fault_detect_en_q &
                     ((is_slave & xfer_active & ss_sync_q & ~ss_prev_q) |
                      (is_master & ~ss_sync_q));

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mode_fault_q <= SSD_FLAG_RST;
      end else if (clk_en) begin
         if (mode_fault_flag_set) begin
            mode_fault_q <= 1'b1;
         end else if (wr_data && mode_fault_flag_arm_q) begin
            mode_fault_q <= 1'b0;
         end
      end
   end

   // slave deselected: output off, clocks ignored
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ss_gpio_sel <= 1'b1;
         miso_oe_n   <= 1'b1;
         sclk_ignore <= 1'b1;
      end else if (clk_en) begin
         ss_gpio_sel <= ~is_on | (is_master & ~fault_detect_en_q);
         miso_oe_n   <= ~(is_slave & ~ss_sync_q);
         sclk_ignore <= ~(is_slave & ~ss_sync_q);
      end
   end

   // ***********************************************
   // transmit side
   // ***********************************************

   // idle shifter takes byte next cycle
   assign tx_go = is_on & ~tx_empty_q & ~xfer_active;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tx_buf_q <= SSD_BYTE_RST;
      end else if (clk_en && wr_data) begin
         tx_buf_q <= reg_wdata;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tx_empty_q <= SSD_TXE_RST;
      end else if (clk_en) begin
         if (wr_data) begin
            tx_empty_q <= 1'b0;  // newest byte still pending
         end else if (tx_go) begin
            tx_empty_q <= 1'b1;
         end
      end
   end

   // one-cycle load pulse with the byte to the shifter
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         shift_load    <= 1'b0;
         shift_tx_byte <= SSD_BYTE_RST;
      end else if (clk_en) begin
         shift_load <= tx_go;
         if (tx_go) begin
            shift_tx_byte <= tx_buf_q;
         end
      end
   end

   // ***********************************************
   // baud generator
   // ***********************************************

   always_comb begin
      case (rate_sel_q)
         2'h0:    divisor = SSD_BD_00;
         2'h1:    divisor = SSD_BD_01;
         2'h2:    divisor = SSD_BD_10;
         default: divisor = SSD_BD_11;
      endcase
   end

   // counter runs only while a master frame is on the wire
   assign baud_run  = is_master & xfer_active;
   assign baud_last = ({1'h0, baud_cnt_q} == (divisor - 8'h01));  // full width so 128 wraps cleanly

   // tick every divisor cycles, engine toggles clock per tick
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         baud_cnt_q <= 7'h00;
         baud_tick  <= 1'b0;
      end else if (clk_en) begin
         if (!baud_run) begin
            baud_cnt_q <= 7'h00;
            baud_tick  <= 1'b0;
         end else if (baud_last) begin
            baud_cnt_q <= 7'h00;
            baud_tick  <= 1'b1;
         end else begin
            baud_cnt_q <= baud_cnt_q + 7'h01;
            baud_tick  <= 1'b0;
         end
      end
   end

   // ***********************************************
   // interrupt request
   // ***********************************************

   assign irq_rx  = rx_full_q & ctrl_q[SSD_CTL_RXIE_BIT];
   assign irq_tx  = tx_empty_q & ctrl_q[SSD_CTL_TXIE_BIT];
   assign irq_err = err_irq_en_q & (overrun_q | mode_fault_q);

   // registered request line
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else if (clk_en) begin
         irq <= irq_rx | irq_tx | irq_err;
      end
   end

endmodule

`default_nettype wire

// File: pkg/ssd_pkg.sv
// constants for the serial status and data buffer block
package ssd_pkg;

   // ***********************************************
   // register offsets
   // ***********************************************
   localparam logic [1:0] SSD_OFF_CTRL   = 2'h0;  // serial_control
   localparam logic [1:0] SSD_OFF_STAT   = 2'h1;  // serial_status_control
   localparam logic [1:0] SSD_OFF_DATA   = 2'h2;  // serial_data_buffer

   // ***********************************************
   // control register fields
   // ***********************************************
   localparam int SSD_CTL_ON_BIT     = 0;  // interface_on
   localparam int SSD_CTL_MSTR_BIT   = 1;  // master_sel
   localparam int SSD_CTL_RXIE_BIT   = 2;  // rx_irq_en
   localparam int SSD_CTL_TXIE_BIT   = 3;  // tx_irq_en
   localparam logic [7:0] SSD_CTL_RST = 8'h02;  // master_sel set

   // ***********************************************
   // status and control register fields
   // ***********************************************
   localparam int SSD_ST_RXF_BIT     = 7;  // rx_full_flag
   localparam int SSD_ST_ERR_IRQ_EN_BIT   = 6;  // err_irq_en
   localparam int SSD_ST_OVR_BIT     = 5;  // overrun_flag
   localparam int SSD_ST_MODE_FAULT_FLAG_BIT    = 4;  // mode_fault_flag
   localparam int SSD_ST_TXE_BIT     = 3;  // tx_empty_flag
   localparam int SSD_ST_FDEN_BIT    = 2;  // fault_detect_en
   localparam int SSD_ST_RHI_BIT     = 1;  // rate_sel_hi
   localparam int SSD_ST_RLO_BIT     = 0;  // rate_sel_lo

   // ***********************************************
   // reset values
   // ***********************************************
   localparam logic       SSD_TXE_RST  = 1'b1;
   localparam logic       SSD_FLAG_RST = 1'b0;
   localparam logic [1:0] SSD_RATE_RST = 2'h0;
   localparam logic [7:0] SSD_BYTE_RST = 8'h00;

   // ***********************************************
   // baud divisors per rate code
   // ***********************************************
   localparam logic [7:0] SSD_BD_00 = 8'h02;  // 2
   localparam logic [7:0] SSD_BD_01 = 8'h08;  // 8
   localparam logic [7:0] SSD_BD_10 = 8'h20;  // 32
   localparam logic [7:0] SSD_BD_11 = 8'h80;  // 128

endpackage

// File: test/ssd_top_asserts.sv
// port checker for the serial status and data buffer block
`timescale 1ns/1ps
`default_nettype none
module ssd_top_asserts
   import ssd_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       rst,
   input wire logic       clk_en,
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       shift_done,
   input wire logic [7:0] shift_rx_byte,
   input wire logic       xfer_active,
   input wire logic       shift_load,
   input wire logic [7:0] shift_tx_byte,
   input wire logic       ss_n_pin,
   input wire logic       ss_gpio_sel,
   input wire logic       miso_oe_n,
   input wire logic       sclk_ignore,
   input wire logic       baud_tick,
   input wire logic       irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // ***************************************
   // assertions
   // ***************************************
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside a read answer");
   load_idle_a: assert property (shift_load |-> !$past(xfer_active))
      else $error("shifter loaded during a transmission");
   baud_gap_a: assert property (baud_tick |=> !baud_tick)
      else $error("baud ticks back to back");
   baud_act_a: assert property (baud_tick |-> $past(xfer_active) || $past(xfer_active, 2))
      else $error("baud tick outside a transmission");
   oe_ignore_a: assert property (miso_oe_n == sclk_ignore)
      else $error("output enable and clock ignore disagree");
   ss_off_a: assert property (ss_n_pin [*4] |=> miso_oe_n)
      else $error("serial output on while select high");
   rx_set_a: assert property (shift_done ##1 (reg_rd && reg_addr == SSD_OFF_STAT)
      |=> reg_rdata[SSD_ST_RXF_BIT])
      else $error("receive full not set after a byte");
   rx_clear_a: assert property ((reg_rd && reg_addr == SSD_OFF_DATA && !shift_done) ##1 !shift_done
      ##1 (reg_rd && reg_addr == SSD_OFF_STAT) |=> !reg_rdata[SSD_ST_RXF_BIT])
      else $error("receive full not cleared by data read");
   txe_set_a: assert property ((shift_load && !reg_wr) ##1 (reg_rd && reg_addr == SSD_OFF_STAT)
      |=> reg_rdata[SSD_ST_TXE_BIT])
      else $error("transmit empty not set after load");
   load_c: cover property (shift_load);
   tick_c: cover property (baud_tick);
   irq_c: cover property ($rose(irq));
endmodule
`default_nettype wire

// File: test/ssd_engine_model.sv
// behavioural shift engine standing beside the buffer block
`timescale 1ns/1ps
`default_nettype none
module ssd_engine_model (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       go,
   input  wire logic [9:0] len,
   input  wire logic [7:0] rx_byte,
   output logic            xfer_active,
   output logic            shift_done,
   output logic      [7:0] shift_rx_byte
);
   logic [9:0] cnt_q;
   // a frame lasts len cycles, byte handed over at its end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_q         <= 10'h000;
         xfer_active   <= 1'h0;
         shift_done    <= 1'h0;
         shift_rx_byte <= 8'hFF;
      end else begin
         shift_done <= 1'h0;
         if (go) begin
            cnt_q       <= len;
            xfer_active <= 1'h1;
         end else if (cnt_q != 10'h000) begin
            cnt_q <= cnt_q - 10'h001;
            if (cnt_q == 10'h001) begin
               xfer_active   <= 1'h0;
               shift_done    <= 1'h1;
               shift_rx_byte <= rx_byte;
            end
         end
         // byte line turns to junk once the done pulse is over
         if (shift_done) shift_rx_byte <= ~shift_rx_byte;
      end
   end
endmodule
`default_nettype wire

// File: test/ssd_top_tb.sv
// register level testbench for the serial status and data buffer block
`timescale 1ns/1ps
`default_nettype none
bind ssd_top ssd_top_asserts u_chk (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .shift_done(shift_done),
   .shift_rx_byte(shift_rx_byte), .xfer_active(xfer_active), .shift_load(shift_load),
   .shift_tx_byte(shift_tx_byte), .ss_n_pin(ss_n_pin), .ss_gpio_sel(ss_gpio_sel), .miso_oe_n(miso_oe_n),
   .sclk_ignore(sclk_ignore), .baud_tick(baud_tick), .irq(irq));
module ssd_top_tb;
   import ssd_pkg::*;
   logic       core_clk, rst, clk_en, reg_wr, reg_rd, go, ss_n_pin;
   logic       shift_done, xfer_active, shift_load, ss_gpio_sel, miso_oe_n, sclk_ignore, baud_tick, irq;
   logic [1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rx_b, shift_rx_byte, shift_tx_byte;
   logic [9:0] len;
   int         fail_count, num_checks, nt, c;
   ssd_top DUT (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .shift_done(shift_done),
      .shift_rx_byte(shift_rx_byte), .xfer_active(xfer_active), .shift_load(shift_load),
      .shift_tx_byte(shift_tx_byte), .ss_n_pin(ss_n_pin), .ss_gpio_sel(ss_gpio_sel), .miso_oe_n(miso_oe_n),
      .sclk_ignore(sclk_ignore), .baud_tick(baud_tick), .irq(irq));
   ssd_engine_model u_eng (.core_clk(core_clk), .rst(rst), .go(go), .len(len), .rx_byte(rx_b),
      .xfer_active(xfer_active), .shift_done(shift_done), .shift_rx_byte(shift_rx_byte));
   // ***************************************
   // bench tasks
   // ***************************************
   initial begin
      core_clk = 1'h0;
      forever #4 core_clk = ~core_clk;
   end
   task automatic complete_run();
      $display("checks %0d fails %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic lost();
      fail_count++;
      $display("BAD %0t wait ran out", $time);
      complete_run();
   endtask
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'h1;
      @(posedge core_clk);
      reg_wr <= 1'h0;
      #1;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'h1;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      #1 chk(reg_rdata, e);
   endtask
   task automatic start(input logic [9:0] n, input logic [7:0] b);
      @(posedge core_clk);
      len  <= n;
      rx_b <= b;
      go   <= 1'h1;
      @(posedge core_clk);
      go <= 1'h0;
   endtask
   // waits for frame end, counting baud ticks on the way
   task automatic await_done();
      int i;
      nt = 0;
      for (i = 0; i < 2000; i++) begin
         @(posedge core_clk);
         #1 if (baud_tick === 1'h1) nt++;
         if (shift_done === 1'h1) break;
      end
      if (i == 2000) lost();
   endtask
   task automatic wload(input logic [7:0] b);
      int i;
      for (i = 0; i < 3; i++) begin
         @(posedge core_clk);
         #1 if (shift_load === 1'h1) break;
      end
      if (i == 3) lost();
      else chk(shift_tx_byte, b);
   endtask
   task automatic gap(input logic [7:0] d);
      int i, n;
      for (i = 0; i < 400; i++) begin
         @(posedge core_clk);
         #1 if (baud_tick === 1'h1) break;
      end
      for (n = 1; n < 300; n++) begin
         @(posedge core_clk);
         #1 if (baud_tick === 1'h1) break;
      end
      if (i == 400 || n == 300) lost();
      else chk(n[7:0], d);
   endtask
   // ***************************************
   // main sequence
   // ***************************************
   initial begin
      {rst, clk_en, reg_wr, reg_rd, go, ss_n_pin} = 6'h31;
      {reg_addr, reg_wdata, rx_b, len} = 28'h0000000;
      fail_count = 0;
      num_checks = 0;
      tick(5);
      rst <= 1'h0;
      rd(SSD_OFF_CTRL, 8'h02);
      rd(SSD_OFF_STAT, 8'h08);
      wr(2'h3, 8'hFF);
      rd(2'h3, 8'h00);
      chk(ss_gpio_sel, 1'h1);
      $display("test reset done");
      wr(SSD_OFF_CTRL, 8'h03);
      wr(SSD_OFF_STAT, 8'h44);
      rd(SSD_OFF_STAT, 8'h4C);
      chk(ss_gpio_sel, 1'h0);
      wr(SSD_OFF_DATA, 8'hA5);
      wload(8'hA5);
      rd(SSD_OFF_STAT, 8'h4C);
      $display("test transmit done");
      for (c = 0; c < 4; c++) begin
         wr(SSD_OFF_STAT, 8'h44 | c[7:0]);
         start(10'h190, c[7:0]);
         gap(8'h02 << (2 * c));
         await_done();
         rd(SSD_OFF_DATA, c[7:0]);
      end
      $display("test baud done");
      start(10'h004, 8'h11);
      await_done();
      start(10'h004, 8'h22);
      await_done();
      rd(SSD_OFF_STAT, 8'hEF);
      chk(irq, 1'h1);
      wr(SSD_OFF_STAT, 8'h07);
      rd(SSD_OFF_STAT, 8'hAF);
      chk(irq, 1'h0);
      wr(SSD_OFF_STAT, 8'h47);
      rd(SSD_OFF_STAT, 8'hEF);
      rd(SSD_OFF_DATA, 8'h11);
      rd(SSD_OFF_STAT, 8'h4F);
      $display("test receive done");
      ss_n_pin <= 1'h0;
      tick(4);
      ss_n_pin <= 1'h1;
      tick(4);
      rd(SSD_OFF_STAT, 8'h5F);
      wr(SSD_OFF_DATA, 8'h3C);
      wload(8'h3C);
      rd(SSD_OFF_STAT, 8'h4F);
      ss_n_pin <= 1'h0;
      tick(4);
      ss_n_pin <= 1'h1;
      tick(4);
      wr(SSD_OFF_STAT, 8'h43);
      rd(SSD_OFF_STAT, 8'h5B);
      chk(ss_gpio_sel, 1'h1);
      wr(SSD_OFF_DATA, 8'h3D);
      wload(8'h3D);
      ss_n_pin <= 1'h0;
      tick(4);
      ss_n_pin <= 1'h1;
      tick(4);
      rd(SSD_OFF_STAT, 8'h4B);
      $display("test master fault done");
      wr(SSD_OFF_CTRL, 8'h05);
      wr(SSD_OFF_STAT, 8'h44);
      chk(ss_gpio_sel, 1'h0);
      chk(miso_oe_n, 1'h1);
      chk(sclk_ignore, 1'h1);
      ss_n_pin <= 1'h0;
      tick(5);
      chk(miso_oe_n, 1'h0);
      chk(sclk_ignore, 1'h0);
      start(10'h01E, 8'h5A);
      wr(SSD_OFF_DATA, 8'h77);
      tick(5);
      ss_n_pin <= 1'h1;
      await_done();
      chk(nt[7:0], 8'h00);
      chk(sclk_ignore, 1'h1);
      wload(8'h77);
      rd(SSD_OFF_STAT, 8'hDC);
      chk(irq, 1'h1);
      wr(SSD_OFF_STAT, 8'h04);
      tick(2);
      chk(irq, 1'h1);
      rd(SSD_OFF_DATA, 8'h5A);
      tick(2);
      chk(irq, 1'h0);
      $display("test slave done");
      clk_en <= 1'h0;
      wr(SSD_OFF_CTRL, 8'h00);
      clk_en <= 1'h1;
      rd(SSD_OFF_CTRL, 8'h05);
      rst <= 1'h1;
      tick(2);
      rst <= 1'h0;
      rd(SSD_OFF_STAT, 8'h08);
      rd(SSD_OFF_CTRL, 8'h02);
      $display("test freeze and reset done");
      complete_run();
   end
endmodule
`default_nettype wire
